// file: hdl/dcc_pkg.sv
// Package for the dual comparator control block.
// Holds register offsets, field positions, reset values and timing counts.
package dcc_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses, one byte register each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG1 = 8'h00;
   localparam logic [7:0] ADDR_CFG2 = 8'h04;
   localparam logic [7:0] ADDR_REFSEL = 8'h08;
   localparam logic [7:0] ADDR_AUXPWR = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_PWR_MODE = 8'h18;
   // ---------------------------------------------------------------
   // Comparator configuration fields
   // ---------------------------------------------------------------
   localparam int CFG_FLAG = 0;
   localparam int CFG_OUT_EN = 1;
   localparam int CFG_RESULT = 2;
   localparam int CFG_NEG_SEL = 3;
   localparam int CFG_POS_SEL = 4;
   localparam int CFG_ENABLE = 5;
   localparam int CFG_IRQ_EN = 6;
   localparam logic [7:0] CFG_WR_MASK = 8'h7b;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Reference select: comparator 1 in [2:0], comparator 2 in [6:4]
   localparam int REF_W = 3;
   localparam int REF1_LSB = 0;
   localparam int REF2_LSB = 4;
   localparam logic [7:0] REFSEL_RESET = 8'h00;
   // Aux power control: comparators off
   localparam int AUX_CMP_OFF = 5;
   localparam logic [7:0] AUXPWR_RESET = 8'h00;
   // Power mode: bit 0 idle, bit 1 power-down, bit 2 total power-down
   localparam int PM_TOTAL = 2;
   // Interrupt status bits
   localparam int ST_CHG1 = 0;
   localparam int ST_CHG2 = 1;
   localparam int ST_SETTLED1 = 2;
   localparam int ST_SETTLED2 = 3;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int SETTLE_US = 10;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int SETTLE_W = 10;
endpackage

// file: hdl/dcc_channel.sv
// One comparator channel: input sync, forcing, settling timer, change flag.
// Assumes the analog decision arrives asynchronously as one bit per
// possible input pairing.
`timescale 1ns/1ps
module dcc_channel #(
   parameter int SETTLE_CYC = dcc_pkg::SETTLE_CYC
)(
   input wire logic ref_clk, // Clock
   input wire logic resetn, // Async reset, active low
   input wire logic [3:0] analog_hi, // Analog decisions {pos,neg} pairs
   input wire logic pos_sel, // Positive input pin select
   input wire logic neg_sel, // Negative input: 1 = internal ref
   input wire logic active, // Enabled and not forced off
   input wire logic flag_clr, // Software writes zero to flag
   output logic result, // Forced/settled result
   output logic flag, // Sticky change flag
   output logic settled_pulse // One cycle when settling ends
);
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic result_reg;
   logic flag_reg;
   logic [dcc_pkg::SETTLE_W-1:0] settle_reg;
   logic settled_reg;
   logic raw;
   logic result_next;

   // Pair index {pos_sel,neg_sel}; high when positive exceeds negative
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end
      else
      begin
         sync1_reg <= analog_hi;
         sync2_reg <= sync1_reg;
      end

   assign raw = sync2_reg[{pos_sel, neg_sel}];

   // Settling count restarts on every enable
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         settle_reg <= '0;
         settled_reg <= 1'b0;
      end
      else if (!active)
      begin
         settle_reg <= '0;
         settled_reg <= 1'b0;
      end
      else if (!settled_reg)
      begin
         settle_reg <= settle_reg + 1'b1;
         settled_reg <= (settle_reg ==
            dcc_pkg::SETTLE_W'(SETTLE_CYC - 1));
      end

   assign settled_pulse = active && !settled_reg &&
      (settle_reg == dcc_pkg::SETTLE_W'(SETTLE_CYC - 1));

   // Output forced high while disabled; raw value only after settling
   always_comb
   begin
      if (!active)
         result_next = 1'b1;
      else if (settled_reg)
         result_next = raw;
      else
         result_next = result_reg;
   end

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         result_reg <= 1'b1;
      else
         result_reg <= result_next;

   // Any change sets the flag, including the forced rise on disable
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         flag_reg <= 1'b0;
      else if (result_next != result_reg)
         flag_reg <= 1'b1;
      else if (flag_clr)
         flag_reg <= 1'b0;

   assign result = result_reg;
   assign flag = flag_reg;
endmodule // dcc_channel

// file: hdl/dcc_ctrl.sv
// Top of the dual comparator control block: registers, power control,
// shared interrupt and wake-up.
// Assumes a simple strobe register port on ref_clk and analog
// decisions arriving asynchronously from the comparator cores.
`timescale 1ns/1ps
// How it works
// - Settled result high only when positive exceeds negative
// - Positive from two pins, negative pin/ref
// - Result and flag held until 10 us settle
// - Disabled comparator output forced high
// - Forced rise sets flag, may interrupt
// - Eight reference levels via select register
// - Separate reference select per comparator
// - Change flag in config register, pollable
// - One shared interrupt for both comparators
// - Enabled comparators run in idle/power-down
// - Total power-down disables both comparators
// - Enabled change interrupts; wakes processor except in total power-down
// - Aux power bit 5 switches comparators off
// - Result readable, optionally driven to pin
module dcc_ctrl #(
   parameter int SETTLE_CYC = dcc_pkg::SETTLE_CYC
)(
   input wire logic ref_clk, // 50 MHz clock
   input wire logic resetn, // Async reset, active low
   input wire logic [7:0] addr, // Register address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after rd
   input wire logic [3:0] cmp1_analog, // Comparator 1 decisions
   input wire logic [3:0] cmp2_analog, // Comparator 2 decisions
   output logic [2:0] ref1_level, // Reference level, comparator 1
   output logic [2:0] ref2_level, // Reference level, comparator 2
   output logic [1:0] cmp_power_on, // Analog core enables
   output logic [1:0] result_pin, // Result pin values
   output logic [1:0] result_pin_oe, // Result pin drive enables
   output logic cmp_irq_req, // Shared comparator request
   output logic wake_req, // Wake processor from sleep
   output logic irq // Masked status interrupt
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] cfg1_reg;
   logic [7:0] cfg2_reg;
   logic [7:0] refsel_reg;
   logic [7:0] auxpwr_reg;
   logic [7:0] pmode_reg;
   logic [7:0] stat_reg;
   logic [7:0] mask_reg;
   logic [7:0] rdata_reg;
   logic [1:0] active_reg;
   logic [1:0] pin_reg;
   logic [1:0] pin_oe_reg;
   logic cmp_irq_reg;
   logic wake_reg;
   logic irq_reg;
   logic [1:0] result;
   logic [1:0] flag;
   logic [1:0] settled;
   logic [1:0] flag_clr;
   logic [1:0] active_next;
   logic [1:0] req_now;
   logic [7:0] stat_ev;
   logic [7:0] rdata_next;

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = wr && (addr == a);
   endfunction

   // Read-back view of a config register: live result and live flag
   // replace the stored bits, so software always sees the channel state
   function automatic logic [7:0] cfg_view(input logic [7:0] cfg,
      input logic res, input logic flg);
      cfg_view = {cfg[7:3], res, cfg[1], flg};
   endfunction

   // ---------------------------------------------------------------
   // Software-written configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         cfg1_reg <= dcc_pkg::CFG_RESET;
         cfg2_reg <= dcc_pkg::CFG_RESET;
      end
      else
      begin
         if (wr_hit(dcc_pkg::ADDR_CFG1))
            cfg1_reg <= wdata & dcc_pkg::CFG_WR_MASK;
         if (wr_hit(dcc_pkg::ADDR_CFG2))
            cfg2_reg <= wdata & dcc_pkg::CFG_WR_MASK;
      end

   // ---------------------------------------------------------------
   // Change-flag clear decode
   // ---------------------------------------------------------------
   // Flag clears when software writes zero to the flag bit. Kept in a
   // process so that the strobe and address read inside wr_hit wake it;
   // a continuous assignment would miss the strobe falling.
   always_comb
   begin
      flag_clr[0] = wr_hit(dcc_pkg::ADDR_CFG1) &&
         !wdata[dcc_pkg::CFG_FLAG];
      flag_clr[1] = wr_hit(dcc_pkg::ADDR_CFG2) &&
         !wdata[dcc_pkg::CFG_FLAG];
   end

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         refsel_reg <= dcc_pkg::REFSEL_RESET;
      else if (wr_hit(dcc_pkg::ADDR_REFSEL))
         refsel_reg <= wdata;

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         auxpwr_reg <= dcc_pkg::AUXPWR_RESET;
      else if (wr_hit(dcc_pkg::ADDR_AUXPWR))
         auxpwr_reg <= wdata;

   // Power mode as reported by the power manager via software
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         pmode_reg <= 8'h00;
      else if (wr_hit(dcc_pkg::ADDR_PWR_MODE))
         pmode_reg <= {5'h00, wdata[2:0]};

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         mask_reg <= dcc_pkg::MASK_RESET;
      else if (wr_hit(dcc_pkg::ADDR_IRQ_MASK))
         mask_reg <= {4'h0, wdata[3:0]};

   // ---------------------------------------------------------------
   // Enables and power gating
   // ---------------------------------------------------------------
   // Idle and power-down leave comparators alone; only the aux bit and
   // total power-down override the enables.
   always_comb
   begin
      active_next[0] = cfg1_reg[dcc_pkg::CFG_ENABLE];
      active_next[1] = cfg2_reg[dcc_pkg::CFG_ENABLE];
      if (auxpwr_reg[dcc_pkg::AUX_CMP_OFF])
         active_next = 2'b00;
      if (pmode_reg[dcc_pkg::PM_TOTAL])
         active_next = 2'b00;
   end

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         active_reg <= 2'b00;
      else
         active_reg <= active_next;

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   dcc_channel #(.SETTLE_CYC(SETTLE_CYC)) u_ch1 (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .analog_hi(cmp1_analog),
      .pos_sel(cfg1_reg[dcc_pkg::CFG_POS_SEL]),
      .neg_sel(cfg1_reg[dcc_pkg::CFG_NEG_SEL]),
      .active(active_reg[0]),
      .flag_clr(flag_clr[0]),
      .result(result[0]),
      .flag(flag[0]),
      .settled_pulse(settled[0])
   );

   dcc_channel #(.SETTLE_CYC(SETTLE_CYC)) u_ch2 (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .analog_hi(cmp2_analog),
      .pos_sel(cfg2_reg[dcc_pkg::CFG_POS_SEL]),
      .neg_sel(cfg2_reg[dcc_pkg::CFG_NEG_SEL]),
      .active(active_reg[1]),
      .flag_clr(flag_clr[1]),
      .result(result[1]),
      .flag(flag[1]),
      .settled_pulse(settled[1])
   );

   // ---------------------------------------------------------------
   // Shared comparator request and wake-up
   // ---------------------------------------------------------------
   assign req_now[0] = flag[0] && cfg1_reg[dcc_pkg::CFG_IRQ_EN];
   assign req_now[1] = flag[1] && cfg2_reg[dcc_pkg::CFG_IRQ_EN];

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         cmp_irq_reg <= 1'b0;
      else
         cmp_irq_reg <= |req_now;

   // No wake from total power-down: both comparators are off there
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         wake_reg <= 1'b0;
      else
         wake_reg <= |req_now && !pmode_reg[dcc_pkg::PM_TOTAL];

   // ---------------------------------------------------------------
   // Pins and reference outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         pin_reg <= 2'b11;
      else
         pin_reg <= result;

   // Drive enable only; the pad mode itself is software's choice
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         pin_oe_reg <= 2'b00;
      else
         pin_oe_reg <= {cfg2_reg[dcc_pkg::CFG_OUT_EN],
            cfg1_reg[dcc_pkg::CFG_OUT_EN]};

   // ---------------------------------------------------------------
   // Status interrupt: sticky, cleared by read, set wins
   // ---------------------------------------------------------------
   assign stat_ev = {4'h0, settled, flag};

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         stat_reg <= 8'h00;
      else if (rd && addr == dcc_pkg::ADDR_IRQ_STAT)
         stat_reg <= stat_ev; // Events of the read cycle survive
      else
         stat_reg <= stat_reg | stat_ev;

   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(stat_reg & mask_reg);

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Unmapped addresses read as zero
   always_comb
   begin
      case (addr)
         dcc_pkg::ADDR_CFG1:
            rdata_next = cfg_view(cfg1_reg, result[0], flag[0]);
         dcc_pkg::ADDR_CFG2:
            rdata_next = cfg_view(cfg2_reg, result[1], flag[1]);
         dcc_pkg::ADDR_REFSEL: rdata_next = refsel_reg;
         dcc_pkg::ADDR_AUXPWR: rdata_next = auxpwr_reg;
         dcc_pkg::ADDR_IRQ_STAT: rdata_next = stat_reg;
         dcc_pkg::ADDR_IRQ_MASK: rdata_next = mask_reg;
         dcc_pkg::ADDR_PWR_MODE: rdata_next = pmode_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         rdata_reg <= 8'h00;
      else if (rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= 8'h00;

   assign rdata = rdata_reg;
   assign ref1_level = refsel_reg[dcc_pkg::REF1_LSB +: dcc_pkg::REF_W];
   assign ref2_level = refsel_reg[dcc_pkg::REF2_LSB +: dcc_pkg::REF_W];
   assign cmp_power_on = active_reg;
   assign result_pin = pin_reg;
   assign result_pin_oe = pin_oe_reg;
   assign cmp_irq_req = cmp_irq_reg;
   assign wake_req = wake_reg;
   assign irq = irq_reg;
endmodule // dcc_ctrl

// file: tb/dcc_ctrl_asserts.sv
// Port-level assertions for the comparator control block.
// Bound into dcc_ctrl; one clock domain, async active-low reset.
`timescale 1ns/1ps
module dcc_ctrl_asserts #(
   parameter int SETTLE_CYC = dcc_pkg::SETTLE_CYC
)(
   input wire logic ref_clk, // Clock
   input wire logic resetn, // Async reset, active low
   input wire logic [7:0] addr, // Register address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic [7:0] rdata, // Read data
   input wire logic [2:0] ref1_level, // Reference level 1
   input wire logic [2:0] ref2_level, // Reference level 2
   input wire logic [1:0] cmp_power_on, // Core enables
   input wire logic [1:0] result_pin, // Result pins
   input wire logic cmp_irq_req, // Shared request
   input wire logic wake_req // Wake request
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_on;
      $rose(cmp_power_on[0]);
   endsequence
   sequence s_held;
      result_pin[0] [*8];
   endsequence
   property p_settle_hold;
      s_on |-> s_held;
   endproperty
   property p_ref;
      wr && addr == dcc_pkg::ADDR_REFSEL |=> ref1_level == $past(wdata[2:0])
         && ref2_level == $past(wdata[6:4]);
   endproperty
   property p_rd_idle;
      !rd |=> rdata == 8'h00;
   endproperty
   property p_aux_off;
      wr && addr == dcc_pkg::ADDR_AUXPWR && wdata[dcc_pkg::AUX_CMP_OFF]
         |-> ##[1:3] cmp_power_on == 2'b00;
   endproperty
   property p_total_off;
      wr && addr == dcc_pkg::ADDR_PWR_MODE && wdata[dcc_pkg::PM_TOTAL]
         |-> ##[1:3] cmp_power_on == 2'b00;
   endproperty
   property p_forced_high;
      (cmp_power_on == 2'b00) [*4] |-> result_pin == 2'b11;
   endproperty
   property p_wake;
      wake_req |-> cmp_irq_req;
   endproperty
   // Idle and power-down writes must leave a running comparator 1 core alone
   property p_idle_keep;
      wr && addr == dcc_pkg::ADDR_PWR_MODE && !wdata[dcc_pkg::PM_TOTAL]
         && cmp_power_on[0] |=> cmp_power_on[0] [*2];
   endproperty
   a_settle_hold: assert property (p_settle_hold)
      else $error("result pin moved during settling");
   a_ref: assert property (p_ref)
      else $error("reference levels do not follow the write");
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");
   a_aux_off: assert property (p_aux_off)
      else $error("aux off bit left a core powered");
   a_total_off: assert property (p_total_off)
      else $error("total power-down left a core powered");
   a_forced_high: assert property (p_forced_high)
      else $error("disabled result not forced high");
   a_wake: assert property (p_wake)
      else $error("wake without comparator request");
   a_idle_keep: assert property (p_idle_keep)
      else $error("core stopped by idle or power-down");
endmodule // dcc_ctrl_asserts

bind dcc_ctrl dcc_ctrl_asserts #(.SETTLE_CYC(SETTLE_CYC)) dcc_ctrl_asserts_i (
   .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .ref1_level(ref1_level),
   .ref2_level(ref2_level), .cmp_power_on(cmp_power_on),
   .result_pin(result_pin), .cmp_irq_req(cmp_irq_req), .wake_req(wake_req)
);

// file: tb/dcc_ctrl_test.sv
// Self-checking bench for the comparator control block.
// Drives the register port and analog decisions; settle shortened to 20.
`timescale 1ns/1ps
module dcc_ctrl_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] cmp1_analog = 4'h0;
   logic [3:0] cmp2_analog = 4'h0;
   logic [7:0] rdata;
   logic [2:0] ref1_level;
   logic [2:0] ref2_level;
   logic [1:0] cmp_power_on;
   logic [1:0] result_pin;
   logic [1:0] result_pin_oe;
   logic cmp_irq_req;
   logic wake_req;
   logic irq;
   int mismatches = 0;
   int comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   dcc_ctrl #(.SETTLE_CYC(20)) dcc_ctrl_i (
      .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cmp1_analog(cmp1_analog),
      .cmp2_analog(cmp2_analog), .ref1_level(ref1_level),
      .ref2_level(ref2_level), .cmp_power_on(cmp_power_on),
      .result_pin(result_pin), .result_pin_oe(result_pin_oe),
      .cmp_irq_req(cmp_irq_req), .wake_req(wake_req), .irq(irq)
   );
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      chk({4'h0, result_pin, result_pin_oe}, 8'h0c);
      rdchk(dcc_pkg::ADDR_CFG1, 8'h04);
      rdchk(dcc_pkg::ADDR_AUXPWR, 8'h00);
      wr8(8'h20, 8'hff);
      rdchk(8'h20, 8'h00);
      rdchk(dcc_pkg::ADDR_IRQ_MASK, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_ref;
      for (int i = 0; i < 8; i++)
      begin
         wr8(dcc_pkg::ADDR_REFSEL, {1'b0, 3'(7 - i), 1'b0, 3'(i)});
         chk({2'b00, ref2_level, ref1_level},
            {2'b00, 3'(7 - i), 3'(i)});
         rdchk(dcc_pkg::ADDR_REFSEL,
            {1'b0, 3'(7 - i), 1'b0, 3'(i)});
      end
      $display("t_ref done");
   endtask
   // Each input pairing selects a decision bit that alone reads low
   task automatic t_cmp1;
      for (int p = 0; p < 4; p++)
      begin
         @(posedge ref_clk);
         cmp1_analog <= ~(4'h1 << p);
         wr8(dcc_pkg::ADDR_CFG1, 8'h22 | 8'(p << 3));
         cyc(12);
         chk(8'(result_pin[0]), 8'h01);
         cyc(20);
         chk({6'h0, result_pin[0], result_pin_oe[0]},
            8'h01);
         rdchk(dcc_pkg::ADDR_CFG1, 8'h23 | 8'(p << 3));
         wr8(dcc_pkg::ADDR_CFG1, 8'h62 | 8'(p << 3));
         cyc(4);
         chk(8'(cmp_irq_req), 8'h00);
         wr8(dcc_pkg::ADDR_CFG1, 8'h40);
         cyc(4);
         chk({5'h0, result_pin[0], cmp_irq_req, wake_req}, 8'h07);
         rdchk(dcc_pkg::ADDR_CFG1, 8'h45);
         wr8(dcc_pkg::ADDR_CFG1, 8'h00);
         cyc(3);
         chk(8'(cmp_irq_req), 8'h00);
      end
      $display("t_cmp1 done");
   endtask
   // Flag cleared by the same write that disables the interrupt
   task automatic t_cmp2;
      @(posedge ref_clk);
      cmp2_analog <= 4'hf;
      wr8(dcc_pkg::ADDR_CFG2, 8'h20);
      cyc(32);
      rdchk(dcc_pkg::ADDR_CFG2, 8'h24);
      wr8(dcc_pkg::ADDR_CFG2, 8'h60);
      wr8(dcc_pkg::ADDR_IRQ_MASK, 8'h02);
      chk({6'h0, cmp_irq_req, irq}, 8'h00);
      @(posedge ref_clk);
      cmp2_analog <= 4'h0;
      cyc(8);
      chk({6'h0, cmp_irq_req, irq}, 8'h03);
      rdchk(dcc_pkg::ADDR_CFG1, 8'h04);
      rdchk(dcc_pkg::ADDR_CFG2, 8'h61);
      wr8(dcc_pkg::ADDR_IRQ_MASK, 8'h00);
      cyc(2);
      chk({6'h0, cmp_irq_req, irq}, 8'h02);
      rdchk(dcc_pkg::ADDR_IRQ_STAT, 8'h0f);
      wr8(dcc_pkg::ADDR_CFG2, 8'h20);
      rdchk(dcc_pkg::ADDR_IRQ_STAT, 8'h02);
      wr8(dcc_pkg::ADDR_IRQ_MASK, 8'h02);
      cyc(2);
      chk({6'h0, cmp_irq_req, irq}, 8'h00);
      $display("t_cmp2 done");
   endtask
   // Comparator 2 sits low with its interrupt on, so the forced rise
   // in total power-down raises a request that must not wake
   task automatic t_power;
      @(posedge ref_clk);
      cmp1_analog <= 4'hf;
      wr8(dcc_pkg::ADDR_CFG2, 8'h60);
      wr8(dcc_pkg::ADDR_CFG1, 8'h20);
      wr8(dcc_pkg::ADDR_PWR_MODE, 8'h03);
      cyc(3);
      chk({6'h0, cmp_power_on}, 8'h03);
      wr8(dcc_pkg::ADDR_PWR_MODE, 8'h04);
      cyc(3);
      chk({6'h0, cmp_power_on}, 8'h00);
      chk({6'h0, cmp_irq_req, wake_req}, 8'h02);
      wr8(dcc_pkg::ADDR_PWR_MODE, 8'h00);
      cyc(3);
      chk({6'h0, cmp_power_on}, 8'h03);
      chk({6'h0, cmp_irq_req, wake_req}, 8'h03);
      wr8(dcc_pkg::ADDR_AUXPWR, 8'h20);
      cyc(3);
      chk({6'h0, cmp_power_on}, 8'h00);
      rdchk(dcc_pkg::ADDR_AUXPWR, 8'h20);
      wr8(dcc_pkg::ADDR_AUXPWR, 8'h00);
      $display("t_power done");
   endtask
   initial
   begin
      #100000;
      mismatches++;
      close_out();
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      cyc(1);
      t_regs();
      t_ref();
      t_cmp1();
      t_cmp2();
      t_power();
      close_out();
   end
endmodule // dcc_ctrl_test
